// [core/irq_map.svh]
/*
 Constants of the prioritized interrupt controller: SFR addresses, field
 positions, write masks, reset values and machine-cycle timing.
 Assumes a host that includes it by bare name before use.
*/
// What this block does
// RQ1: Two priority bits give each source four levels
// RQ2: Only strictly higher level preempts running handler
// RQ3: Higher level wins among simultaneous requests
// RQ4: Equal level resolved by fixed polling order
// RQ5: Sample at fetch, poll in next fetch
// RQ6: No call while equal/higher level in progress
// RQ7: Call only at last cycle of instruction
// RQ8: Return or priority write defers one instruction
// RQ9: No call during program memory update
// RQ10: Refused requests are forgotten, resampled later
// RQ11: Higher request vectored during lower vectoring
// RQ12: Call pushes PC, not status word, then branches
// RQ13: Vectors from 0003H in steps of eight
// RQ14: Serial flags kept; external cleared if edge
// RQ15: Return clears in-progress marker, restores PC
// RQ16: Handlers must exit with interrupt return
// RQ17: Overflow flag set by hardware/software, software-cleared
// RQ18: Module flags set by hardware, software-cleared
// RQ19: Compare match sets flag only if enabled
// RQ20: Wake enables let configured sources leave power-down
// RQ21: Global enable gates all individual enables
// RQ22: Edge mode high-then-low; level mode low requests
// RQ23: One in-progress marker per priority level
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

`define IRQ_NSRC 10
`define IRQ_SRC_W 4
`define IRQ_LVL_W 2
`define IRQ_LEVELS 4

`define IRQ_SFR_WAKE 8'h8F
`define IRQ_SFR_IE 8'hA8
`define IRQ_SFR_IE2 8'hAF
`define IRQ_SFR_IPH 8'hB7
`define IRQ_SFR_IP 8'hB8
`define IRQ_SFR_IP2 8'hB5
`define IRQ_SFR_SECOND_PRIORITY_HIGH 8'hB6
`define IRQ_SFR_PCA_CONTROL_FLAGS 8'hD8
`define IRQ_SFR_PCA_MODE_CONFIG 8'hD9
`define IRQ_SFR_PCA_MODULE0_MODE 8'hDA
`define IRQ_SFR_PCA_MODULE1_MODE 8'hDB

`define IRQ_GLOBAL_EN_BIT 7
`define IRQ_CF_BIT 7
`define IRQ_CR_BIT 6
`define IRQ_ECF_BIT 0
`define IRQ_ECCF_BIT 0
`define IRQ_MAT_BIT 3
`define IRQ_WAKE_PCA_BIT 7
`define IRQ_WAKE_LVD_BIT 3

`define IRQ_PCA_CONTROL_FLAGS_MASK 8'hC3
`define IRQ_PCA_MODE_CONFIG_MASK 8'h8F
`define IRQ_CCAPM_MASK 8'h7F
`define IRQ_WAKE_MASK 8'hFB
`define IRQ_REG_RESET 8'h00

`define IRQ_VEC_BASE 16'h0003
`define IRQ_CLK_PER_MC 12
`define IRQ_CALL_MC 2

`endif

// [core/irq_pkg.sv]
/*
 Types shared by both ends of the interrupt link.
 Assumes the map header is compiled alongside.
*/
package irq_pkg;
    typedef logic [1:0] irq_level_t;
    typedef logic [3:0] irq_src_t;
    typedef enum logic [1:0] {CTL_IDLE = 2'b01, CTL_WAIT = 2'b10} ctl_state_t;
    typedef enum logic [1:0] {SEQ_RUN = 2'b01, SEQ_CALL = 2'b10} seq_state_t;
endpackage

// [core/irq_link_if.sv]
/*
 Link between the interrupt controller and the CPU sequencer.
 Assumes one common clock; every signal is driven from a flip-flop.
*/
`timescale 1ns/1ns
`include "irq_map.svh"
interface irq_link_if;
    logic machine_tick;
    logic fetch_edge;
    logic poll_strobe;
    logic instr_last;
    logic return_from_irq_instr_exec;
    logic sfr_we;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic call_req;
    logic [15:0] call_vector;
    irq_pkg::irq_level_t call_level;
    logic call_ack;

    modport ctl (
        input machine_tick, fetch_edge, poll_strobe, instr_last, return_from_irq_instr_exec,
        input sfr_we, sfr_addr, sfr_wdata, call_ack,
        output sfr_rdata, call_req, call_vector, call_level
    );
    modport seq (
        output machine_tick, fetch_edge, poll_strobe, instr_last, return_from_irq_instr_exec,
        output sfr_we, sfr_addr, sfr_wdata, call_ack,
        input sfr_rdata, call_req, call_vector, call_level
    );
endinterface

// [core/irq_priority_pick.sv]
/*
 Picks the pending source of highest level, lowest index within a level.
 Assumes purely combinational use inside the controller.
*/
`timescale 1ns/1ns
module irq_priority_pick #(
    parameter int N = 10
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] lvl_lo,
    input wire logic [N-1:0] lvl_hi,
    output logic any,
    output irq_pkg::irq_src_t idx,
    output irq_pkg::irq_level_t lvl
);
    if (N < 1 || N > 16) begin : g_chk
        $error("irq_priority_pick: N must be 1..16");
    end

    always_comb begin
        any = 1'b0;
        idx = '0;
        lvl = '0;
        // Descending scan with >= lets the lower index win a tie
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && (!any || {lvl_hi[i], lvl_lo[i]} >= lvl)) begin // [RQ3] [RQ4]
                any = 1'b1;
                idx = 4'(i);
                lvl = {lvl_hi[i], lvl_lo[i]};
            end
        end
    end
endmodule

// [core/irq_controller.sv]
/*
 Interrupt controller end: enables, priorities, sampling and polling,
 in-progress markers, PCA flags and modes, power-down wake enables.
 Assumes the sequencer end on the link and level flags from peripherals.
*/
`timescale 1ns/1ns
`include "irq_map.svh"
module irq_controller #(
    parameter int NSRC = `IRQ_NSRC
) (
    input wire logic clock,
    input wire logic rst,
    irq_link_if.ctl link,
    input wire logic ext0_pin_n,
    input wire logic ext1_pin_n,
    input wire logic ext0_edge_mode,
    input wire logic ext1_edge_mode,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag,
    input wire logic serial_flag,
    input wire logic converter_flag,
    input wire logic low_voltage_flag,
    input wire logic serial2_flag,
    input wire logic spi_flag,
    input wire logic pca_rollover,
    input wire logic [1:0] pca_match,
    input wire logic [1:0] pca_capture,
    input wire logic program_memory_update,
    input wire logic power_down,
    input wire logic [4:0] wake_activity,
    output logic [1:0] ext_request_flag,
    output logic [1:0] timer_flag_clear,
    output logic counter_run,
    output logic [7:0] pca_mode_config,
    output logic [7:0] pca_module0_mode,
    output logic [7:0] pca_module1_mode,
    output logic [1:0] clock_out_enable,
    output logic wake_req
);
    if (NSRC != `IRQ_NSRC) begin : g_chk
        $error("irq_controller: source map is fixed at ten sources");
    end

    function automatic logic [2:0] top_active(input logic [3:0] act);
        top_active = 3'h0;
        for (int l = 0; l < `IRQ_LEVELS; l++) begin
            if (act[l]) begin
                top_active = {1'b1, 2'(l)};
            end
        end
    endfunction

    logic [7:0] ie_ff, ie2_ff, ipl_ff, iph_ff, ip2l_ff, second_priority_high_ff;
    logic [7:0] pca_control_flags_ff, pca_mode_config_ff, capm0_ff, capm1_ff, wake_ff, rdata_ff;
    logic [7:0] nxt_ie, nxt_ie2, nxt_ipl, nxt_iph, nxt_ip2l, nxt_second_priority_high;
    logic [7:0] nxt_pca_control_flags, nxt_pca_mode_config, nxt_capm0, nxt_capm1, nxt_wake, nxt_rdata;
    logic ctl_write;

    // SFR group
    always_comb begin
        nxt_ie = ie_ff;
        nxt_ie2 = ie2_ff;
        nxt_ipl = ipl_ff;
        nxt_iph = iph_ff;
        nxt_ip2l = ip2l_ff;
        nxt_second_priority_high = second_priority_high_ff;
        nxt_pca_control_flags = pca_control_flags_ff;
        nxt_pca_mode_config = pca_mode_config_ff;
        nxt_capm0 = capm0_ff;
        nxt_capm1 = capm1_ff;
        nxt_wake = wake_ff;
        ctl_write = 1'b0;
        if (link.sfr_we) begin
            unique case (link.sfr_addr)
                `IRQ_SFR_IE: begin nxt_ie = link.sfr_wdata; ctl_write = 1'b1; end
                `IRQ_SFR_IE2: begin nxt_ie2 = link.sfr_wdata; ctl_write = 1'b1; end
                `IRQ_SFR_IP: begin nxt_ipl = link.sfr_wdata; ctl_write = 1'b1; end // [RQ1]
                `IRQ_SFR_IPH: begin nxt_iph = link.sfr_wdata; ctl_write = 1'b1; end // [RQ1]
                `IRQ_SFR_IP2: begin nxt_ip2l = link.sfr_wdata; ctl_write = 1'b1; end
                `IRQ_SFR_SECOND_PRIORITY_HIGH: begin nxt_second_priority_high = link.sfr_wdata; ctl_write = 1'b1; end
                `IRQ_SFR_PCA_CONTROL_FLAGS: nxt_pca_control_flags = link.sfr_wdata & `IRQ_PCA_CONTROL_FLAGS_MASK; // [RQ17] [RQ18]
                `IRQ_SFR_PCA_MODE_CONFIG: nxt_pca_mode_config = link.sfr_wdata & `IRQ_PCA_MODE_CONFIG_MASK;
                `IRQ_SFR_PCA_MODULE0_MODE: nxt_capm0 = link.sfr_wdata & `IRQ_CCAPM_MASK;
                `IRQ_SFR_PCA_MODULE1_MODE: nxt_capm1 = link.sfr_wdata & `IRQ_CCAPM_MASK;
                `IRQ_SFR_WAKE: nxt_wake = link.sfr_wdata & `IRQ_WAKE_MASK; // [RQ20]
                default: ;
            endcase
        end
        // Hardware sets override a software clear in the same cycle
        if (pca_rollover) begin
            nxt_pca_control_flags[`IRQ_CF_BIT] = 1'b1; // [RQ17]
        end
        if (pca_capture[0] || (pca_match[0] && capm0_ff[`IRQ_MAT_BIT])) begin // [RQ19]
            nxt_pca_control_flags[0] = 1'b1; // [RQ18]
        end
        if (pca_capture[1] || (pca_match[1] && capm1_ff[`IRQ_MAT_BIT])) begin // [RQ19]
            nxt_pca_control_flags[1] = 1'b1; // [RQ18]
        end
        unique case (link.sfr_addr)
            `IRQ_SFR_IE: nxt_rdata = ie_ff;
            `IRQ_SFR_IE2: nxt_rdata = ie2_ff;
            `IRQ_SFR_IP: nxt_rdata = ipl_ff;
            `IRQ_SFR_IPH: nxt_rdata = iph_ff;
            `IRQ_SFR_IP2: nxt_rdata = ip2l_ff;
            `IRQ_SFR_SECOND_PRIORITY_HIGH: nxt_rdata = second_priority_high_ff;
            `IRQ_SFR_PCA_CONTROL_FLAGS: nxt_rdata = pca_control_flags_ff;
            `IRQ_SFR_PCA_MODE_CONFIG: nxt_rdata = pca_mode_config_ff;
            `IRQ_SFR_PCA_MODULE0_MODE: nxt_rdata = capm0_ff;
            `IRQ_SFR_PCA_MODULE1_MODE: nxt_rdata = capm1_ff;
            `IRQ_SFR_WAKE: nxt_rdata = wake_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ie_ff <= `IRQ_REG_RESET;
            ie2_ff <= `IRQ_REG_RESET;
            ipl_ff <= `IRQ_REG_RESET;
            iph_ff <= `IRQ_REG_RESET;
            ip2l_ff <= `IRQ_REG_RESET;
            second_priority_high_ff <= `IRQ_REG_RESET;
            pca_control_flags_ff <= `IRQ_REG_RESET;
            pca_mode_config_ff <= `IRQ_REG_RESET;
            capm0_ff <= `IRQ_REG_RESET;
            capm1_ff <= `IRQ_REG_RESET;
            wake_ff <= `IRQ_REG_RESET;
            rdata_ff <= `IRQ_REG_RESET;
        end else begin
            ie_ff <= nxt_ie;
            ie2_ff <= nxt_ie2;
            ipl_ff <= nxt_ipl;
            iph_ff <= nxt_iph;
            ip2l_ff <= nxt_ip2l;
            second_priority_high_ff <= nxt_second_priority_high;
            pca_control_flags_ff <= nxt_pca_control_flags;
            pca_mode_config_ff <= nxt_pca_mode_config;
            capm0_ff <= nxt_capm0;
            capm1_ff <= nxt_capm1;
            wake_ff <= nxt_wake;
            rdata_ff <= nxt_rdata;
        end
    end

    logic pca_irq;
    logic [NSRC-1:0] enabled, req, lvl_lo, lvl_hi;
    logic pick_any;
    irq_pkg::irq_src_t pick_idx;
    irq_pkg::irq_level_t pick_lvl;

    assign pca_irq = (pca_control_flags_ff[`IRQ_CF_BIT] & pca_mode_config_ff[`IRQ_ECF_BIT])
        | (pca_control_flags_ff[0] & capm0_ff[`IRQ_ECCF_BIT])
        | (pca_control_flags_ff[1] & capm1_ff[`IRQ_ECCF_BIT]); // [RQ17] [RQ18]
    // PCA has no individual bit; its own enables gate it
    assign enabled = {ie2_ff[1:0], 1'b1, ie_ff[6:0]}
        & {NSRC{ie_ff[`IRQ_GLOBAL_EN_BIT]}}; // [RQ21]
    assign req = {spi_flag, serial2_flag, pca_irq, low_voltage_flag, converter_flag,
        serial_flag, timer1_overflow_flag, ext_request_flag[1],
        timer0_overflow_flag, ext_request_flag[0]};
    assign lvl_lo = {ip2l_ff[1:0], ipl_ff}; // [RQ1]
    assign lvl_hi = {second_priority_high_ff[1:0], iph_ff}; // [RQ1]

    logic [NSRC-1:0] samp_ff, nxt_samp;
    irq_priority_pick #(.N(NSRC)) u_pick (
        .req(samp_ff),
        .lvl_lo(lvl_lo),
        .lvl_hi(lvl_hi),
        .any(pick_any),
        .idx(pick_idx),
        .lvl(pick_lvl)
    );

    irq_pkg::ctl_state_t state_ff, nxt_state;
    logic [3:0] active_ff, nxt_active;
    logic defer_ff, nxt_defer, req_ff, nxt_req;
    logic [15:0] vec_ff, nxt_vec;
    irq_pkg::irq_level_t lvl_ff, nxt_lvl;
    irq_pkg::irq_src_t src_ff, nxt_src;
    logic [1:0] ext_prev_ff, nxt_ext_prev, ext_flag_ff, nxt_ext_flag;
    logic [1:0] tclr_ff, nxt_tclr;
    logic wake_req_ff, nxt_wake_req;
    logic [2:0] top;
    logic poll_now, allow;
    logic [1:0] pins, edge_mode, ack_ext;
    logic [4:0] wake_cfg;

    assign pins = {ext1_pin_n, ext0_pin_n};
    assign edge_mode = {ext1_edge_mode, ext0_edge_mode};

    // Polling, vectoring and in-progress group
    always_comb begin
        top = top_active(active_ff);
        poll_now = link.poll_strobe & link.instr_last; // [RQ7]
        allow = poll_now && pick_any && state_ff == irq_pkg::CTL_IDLE
            && !defer_ff && !ctl_write && !link.return_from_irq_instr_exec // [RQ8]
            && !program_memory_update // [RQ9]
            && (!top[2] || pick_lvl > top[1:0]); // [RQ2] [RQ6]
        // Fresh samples each fetch; a refused request leaves no trace
        nxt_samp = link.fetch_edge ? (req & enabled) : samp_ff; // [RQ5] [RQ10]
        nxt_state = state_ff;
        nxt_active = active_ff;
        nxt_req = req_ff;
        nxt_vec = vec_ff;
        nxt_lvl = lvl_ff;
        nxt_src = src_ff;
        nxt_tclr = 2'b00;
        ack_ext = 2'b00;
        nxt_defer = poll_now ? 1'b0 : defer_ff;
        if (ctl_write || link.return_from_irq_instr_exec) begin
            nxt_defer = 1'b1; // [RQ8]
        end
        if (link.return_from_irq_instr_exec && top[2]) begin
            nxt_active[top[1:0]] = 1'b0; // [RQ15] [RQ23]
        end
        unique case (state_ff)
            irq_pkg::CTL_IDLE: begin
                if (allow) begin
                    nxt_state = irq_pkg::CTL_WAIT;
                    nxt_req = 1'b1;
                    nxt_vec = `IRQ_VEC_BASE + {9'h000, pick_idx, 3'h0}; // [RQ13]
                    nxt_lvl = pick_lvl;
                    nxt_src = pick_idx;
                end
            end
            irq_pkg::CTL_WAIT: begin
                // Polling resumes after the call is taken, so a higher
                // request can still vector before the handler runs
                if (link.call_ack) begin // [RQ11] [RQ12]
                    nxt_state = irq_pkg::CTL_IDLE;
                    nxt_req = 1'b0;
                    nxt_active[lvl_ff] = 1'b1; // [RQ23]
                    nxt_tclr = {src_ff == 4'h3, src_ff == 4'h1};
                    ack_ext = {src_ff == 4'h2, src_ff == 4'h0} & edge_mode; // [RQ14]
                end
            end
        endcase
        nxt_ext_prev = link.machine_tick ? pins : ext_prev_ff;
        for (int e = 0; e < 2; e++) begin
            nxt_ext_flag[e] = ext_flag_ff[e] & ~ack_ext[e];
            if (!edge_mode[e]) begin
                nxt_ext_flag[e] = link.machine_tick ? ~pins[e] : ext_flag_ff[e]; // [RQ22]
            end else if (link.machine_tick && ext_prev_ff[e] && !pins[e]) begin
                nxt_ext_flag[e] = 1'b1; // [RQ22]
            end
        end
        wake_cfg = {enabled[7] & (pca_mode_config_ff[`IRQ_ECF_BIT] | capm0_ff[`IRQ_ECCF_BIT]
            | capm1_ff[`IRQ_ECCF_BIT]), enabled[4], enabled[3], enabled[1], enabled[6]};
        nxt_wake_req = power_down
            & |(wake_activity & wake_ff[`IRQ_WAKE_PCA_BIT:`IRQ_WAKE_LVD_BIT] & wake_cfg); // [RQ20]
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= irq_pkg::CTL_IDLE;
            active_ff <= 4'h0;
            defer_ff <= 1'b0;
            req_ff <= 1'b0;
            vec_ff <= 16'h0000;
            lvl_ff <= 2'h0;
            src_ff <= 4'h0;
            samp_ff <= '0;
            ext_prev_ff <= 2'h3;
            ext_flag_ff <= 2'h0;
            tclr_ff <= 2'h0;
            wake_req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            active_ff <= nxt_active;
            defer_ff <= nxt_defer;
            req_ff <= nxt_req;
            vec_ff <= nxt_vec;
            lvl_ff <= nxt_lvl;
            src_ff <= nxt_src;
            samp_ff <= nxt_samp;
            ext_prev_ff <= nxt_ext_prev;
            ext_flag_ff <= nxt_ext_flag;
            tclr_ff <= nxt_tclr;
            wake_req_ff <= nxt_wake_req;
        end
    end

    assign link.sfr_rdata = rdata_ff;
    assign link.call_req = req_ff;
    assign link.call_vector = vec_ff;
    assign link.call_level = lvl_ff;
    assign ext_request_flag = ext_flag_ff;
    assign timer_flag_clear = tclr_ff;
    assign counter_run = pca_control_flags_ff[`IRQ_CR_BIT];
    assign pca_mode_config = pca_mode_config_ff;
    assign pca_module0_mode = capm0_ff;
    assign pca_module1_mode = capm1_ff;
    assign clock_out_enable = wake_ff[1:0];
    assign wake_req = wake_req_ff;
endmodule

// [core/irq_sequencer.sv]
/*
 CPU sequencer end: machine-cycle timing, fetch and poll strobes,
 SFR access forwarding and the hardware call that takes a vector.
 Assumes the core supplies instruction length and kind at each fetch.
*/
`timescale 1ns/1ns
`include "irq_map.svh"
module irq_sequencer #(
    parameter int CLK_PER_MC = `IRQ_CLK_PER_MC,
    parameter int CALL_MC = `IRQ_CALL_MC
) (
    input wire logic clock,
    input wire logic rst,
    irq_link_if.seq link,
    input wire logic [2:0] instr_len,
    input wire logic instr_is_return_from_irq_instr,
    input wire logic sfr_we_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic instr_start,
    output logic pc_push,
    output logic [15:0] branch_addr,
    output logic [7:0] sfr_rdata_out
);
    if (CLK_PER_MC < 3 || CLK_PER_MC > 16 || CALL_MC < 1 || CALL_MC > 7) begin : g_chk
        $error("irq_sequencer: unsupported timing parameters");
    end

    irq_pkg::seq_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [2:0] mc_ff, nxt_mc, len_ff, nxt_len;
    logic start_ff, nxt_start, push_ff, nxt_push, ack_ff, nxt_ack, return_from_irq_instr_ff, nxt_return_from_irq_instr;
    logic [15:0] branch_ff, nxt_branch;
    logic tick_ff, fetch_ff, last_ff, nxt_last;
    logic tick, boundary, decide;

    always_comb begin
        tick = cnt_ff == 4'(CLK_PER_MC - 1);
        nxt_last = mc_ff == (len_ff - 3'h1);
        boundary = tick & nxt_last;
        decide = cnt_ff == 4'h1 && mc_ff == 3'h0;
        nxt_cnt = tick ? 4'h0 : cnt_ff + 4'h1;
        nxt_mc = boundary ? 3'h0 : (tick ? mc_ff + 3'h1 : mc_ff);
        nxt_state = state_ff;
        nxt_len = len_ff;
        nxt_start = 1'b0;
        nxt_push = 1'b0;
        nxt_ack = 1'b0;
        nxt_return_from_irq_instr = 1'b0;
        nxt_branch = branch_ff;
        if (decide) begin
            // A call taken here replaces the instruction just fetched
            if (link.call_req) begin // [RQ7]
                nxt_state = irq_pkg::SEQ_CALL;
                nxt_len = 3'(CALL_MC);
                nxt_ack = 1'b1;
                nxt_push = 1'b1; // [RQ12]
                nxt_branch = link.call_vector;
            end else begin
                nxt_state = irq_pkg::SEQ_RUN;
                nxt_len = (instr_len == 3'h0) ? 3'h1 : instr_len;
                nxt_start = 1'b1;
                nxt_return_from_irq_instr = instr_is_return_from_irq_instr; // [RQ15] [RQ16]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= irq_pkg::SEQ_RUN;
            cnt_ff <= 4'h0;
            mc_ff <= 3'h0;
            len_ff <= 3'h1;
            start_ff <= 1'b0;
            push_ff <= 1'b0;
            ack_ff <= 1'b0;
            return_from_irq_instr_ff <= 1'b0;
            branch_ff <= 16'h0000;
            tick_ff <= 1'b0;
            fetch_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            mc_ff <= nxt_mc;
            len_ff <= nxt_len;
            start_ff <= nxt_start;
            push_ff <= nxt_push;
            ack_ff <= nxt_ack;
            return_from_irq_instr_ff <= nxt_return_from_irq_instr;
            branch_ff <= nxt_branch;
            tick_ff <= tick;
            fetch_ff <= boundary;
            last_ff <= nxt_last;
        end
    end

    logic we_ff;
    logic [7:0] addr_ff, wdata_ff, rdata_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            we_ff <= 1'b0;
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
        end else begin
            we_ff <= sfr_we_in;
            addr_ff <= sfr_addr_in;
            wdata_ff <= sfr_wdata_in;
            rdata_ff <= link.sfr_rdata;
        end
    end

    assign link.machine_tick = tick_ff;
    assign link.fetch_edge = fetch_ff;
    assign link.poll_strobe = tick_ff;
    assign link.instr_last = last_ff;
    assign link.return_from_irq_instr_exec = return_from_irq_instr_ff;
    assign link.sfr_we = we_ff;
    assign link.sfr_addr = addr_ff;
    assign link.sfr_wdata = wdata_ff;
    assign link.call_ack = ack_ff;
    assign instr_start = start_ff;
    assign pc_push = push_ff;
    assign branch_addr = branch_ff;
    assign sfr_rdata_out = rdata_ff;
endmodule

// [verification/irq_link_sva.sv]
/*
 Checker of the interrupt link between controller and sequencer.
 Assumes instantiation beside the link in the bench top, one clock.
*/
`timescale 1ns/1ns
module irq_link_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic poll_strobe,
    input wire logic instr_last,
    input wire logic return_from_irq_instr_exec,
    input wire logic call_req,
    input wire logic [15:0] call_vector,
    input wire irq_pkg::irq_level_t call_level,
    input wire logic call_ack
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_req_held_ack: assert property (call_req && !call_ack |=> call_req)
        else $error("call request dropped before ack");
    a_vector_steady: assert property (call_req && !call_ack |=> $stable(call_vector)
        && $stable(call_level)) else $error("vector changed while requested");
    a_vector_map: assert property (call_req |-> call_vector[2:0] == 3'h3
        && call_vector <= 16'h004B) else $error("vector outside table");
    a_call_at_end: assert property ($rose(call_req) |-> $past(poll_strobe)
        && $past(instr_last)) else $error("call not at instruction end");
    a_ack_bounded: assert property ($rose(call_req) |-> ##[1:64] call_ack)
        else $error("call never taken");
    a_ack_drops_req: assert property (call_ack |=> !call_req)
        else $error("request kept after ack");
    a_ack_single: assert property (call_ack |=> !call_ack)
        else $error("ack longer than one clock");
    a_return_defers: assert property (return_from_irq_instr_exec |=> !call_req [*2])
        else $error("call right after return");
endmodule

// [verification/prioritized_irq_controller_tb.sv]
/*
 Bench joining controller and sequencer over the link.
 Assumes a short machine cycle of three clocks.
*/
`timescale 1ns/1ns
module prioritized_irq_controller_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] instr_len = 3'h1;
    logic instr_is_return_from_irq_instr = 1'b0;
    logic sfr_we_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [1:0] ext_n = 2'h3;
    logic [1:0] tflag = 2'h0;
    logic [4:0] sflag = 5'h00;
    logic [4:0] pca_in = 5'h00;
    logic [1:0] timer_flag_clear;
    logic [1:0] last_clear = 2'h0;
    logic prog_busy = 1'b0;
    logic [1:0] ext_flag;
    logic cnt_run;
    logic instr_start;
    logic pc_push;
    logic [15:0] branch_addr;
    logic [7:0] sfr_rdata_out;
    int pushes = 0;
    int mismatches = 0;
    int num_checks = 0;

    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (pc_push === 1'b1)
            pushes <= pushes + 1;
        if (timer_flag_clear !== 2'h0)
            last_clear <= timer_flag_clear;
    end

    irq_link_if irq_link_if_i ();
    irq_sequencer #(.CLK_PER_MC(3)) irq_sequencer_i (.clock, .rst, .link(irq_link_if_i),
        .instr_len, .instr_is_return_from_irq_instr, .sfr_we_in, .sfr_addr_in, .sfr_wdata_in,
        .instr_start, .pc_push, .branch_addr, .sfr_rdata_out);
    irq_controller irq_controller_i (.clock, .rst, .link(irq_link_if_i),
        .ext0_pin_n(ext_n[0]), .ext1_pin_n(ext_n[1]), .ext0_edge_mode(1'b1),
        .ext1_edge_mode(1'b0), .timer0_overflow_flag(tflag[0]),
        .timer1_overflow_flag(tflag[1]), .serial_flag(sflag[0]), .converter_flag(sflag[1]),
        .low_voltage_flag(sflag[2]), .serial2_flag(sflag[3]), .spi_flag(sflag[4]),
        .pca_rollover(pca_in[4]), .pca_match(pca_in[3:2]), .pca_capture(pca_in[1:0]),
        .program_memory_update(prog_busy), .power_down(1'b0), .wake_activity(5'h00),
        .ext_request_flag(ext_flag), .timer_flag_clear, .counter_run(cnt_run),
        .pca_mode_config(),
        .pca_module0_mode(), .pca_module1_mode(), .clock_out_enable(), .wake_req());
    irq_link_sva irq_link_sva_i (.clock, .rst, .poll_strobe(irq_link_if_i.poll_strobe),
        .instr_last(irq_link_if_i.instr_last), .return_from_irq_instr_exec(irq_link_if_i.return_from_irq_instr_exec),
        .call_req(irq_link_if_i.call_req), .call_vector(irq_link_if_i.call_vector),
        .call_level(irq_link_if_i.call_level), .call_ack(irq_link_if_i.call_ack));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_we_in = 1'b1;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        @(negedge clock);
        sfr_we_in = 1'b0;
    endtask

    task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        sfr_addr_in = a;
        repeat (3) @(negedge clock);
        check({8'h00, sfr_rdata_out}, {8'h00, exp});
    endtask

    task automatic pca_pulse(input logic [4:0] v);
        @(negedge clock);
        pca_in = v;
        @(negedge clock);
        pca_in = 5'h00;
    endtask

    task automatic wait_call(input logic [15:0] exp, input int want);
        int n;
        n = pushes;
        for (int i = 0; i < 200 && pushes == n; i++) @(negedge clock);
        check(16'(pushes - n), 16'(want));
        if (want == 1)
            check(branch_addr, exp);
    endtask

    task automatic return_from_irq_instr();
        @(negedge clock);
        instr_is_return_from_irq_instr = 1'b1;
        @(negedge clock);
        for (int i = 0; i < 20 && instr_start !== 1'b1; i++) @(negedge clock);
        instr_is_return_from_irq_instr = 1'b0;
    endtask

    initial begin
        #400000;
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        sfr_chk(8'hD8, 8'h00);
        sfr_chk(8'hB9, 8'h00);
        sfr_wr(8'hA8, 8'h8A);
        sfr_wr(8'hB8, 8'h00);
        tflag = 2'h3;
        wait_call(16'h000B, 1);
        // Clear pulse lands one clock after the push
        @(negedge clock);
        check({14'h0, last_clear}, 16'h0001);
        tflag = 2'h2;
        wait_call(16'h0000, 0);
        prog_busy = 1'b1;
        sfr_wr(8'hB8, 8'h08);
        sfr_chk(8'hB8, 8'h08);
        wait_call(16'h0000, 0);
        prog_busy = 1'b0;
        wait_call(16'h001B, 1);
        // Timer 1 stays pending so the return defer is exercised
        return_from_irq_instr();
        tflag = 2'h2;
        wait_call(16'h001B, 1);
        tflag = 2'h0;
        sfr_wr(8'hD8, 8'hC0);
        sfr_chk(8'hD8, 8'hC0);
        check({15'h0000, cnt_run}, 16'h0001);
        sfr_wr(8'hD8, 8'h00);
        pca_pulse(5'h10);
        sfr_chk(8'hD8, 8'h80);
        pca_pulse(5'h04);
        sfr_chk(8'hD8, 8'h80);
        sfr_wr(8'hDA, 8'h08);
        pca_pulse(5'h04);
        pca_pulse(5'h02);
        sfr_chk(8'hD8, 8'h83);
        // Pin 0 edge mode sees high then low, pin 1 level mode sees low
        ext_n = 2'h0;
        repeat (6) @(negedge clock);
        check({14'h0, ext_flag}, 16'h0003);
        finish_test();
    end
endmodule
